// >>> hdl/pmaddr_map.svh
/*
  Constants for the program memory addressing block: widths, vectors, sizes.
  Assumes inclusion by bare name from the package and modules.
*/
`ifndef PMADDR_MAP_SVH
`define PMADDR_MAP_SVH
`define PMA_PC_W        13
`define PMA_WORD_W      14
`define PMA_DATA_AW     9
`define PMA_DATA_W      8
`define PMA_RESET_VEC   13'h0000
`define PMA_INT_VEC     13'h0004
`define PMA_WORDS_BIG   8192
`define PMA_WORDS_SMALL 4096
`endif

// >>> hdl/pma_pkg.sv
/*
  Types for the program memory addressing block.
  Assumes the map header is on the include path.
*/
`include "pmaddr_map.svh"
package pma_pkg;
  typedef logic [`PMA_PC_W-1:0]   pma_pc_t;
  typedef logic [`PMA_WORD_W-1:0] pma_word_t;
  typedef enum logic [1:0] {
    PMA_RESET = 2'b00,
    PMA_RUN   = 2'b01,
    PMA_VECT  = 2'b10
  } pma_state_t;
endpackage

// >>> hdl/pma_rom_if.sv
/*
  Interface between the address former and the program word store.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "pmaddr_map.svh"
interface pma_rom_if;
  import pma_pkg::*;
  logic [`PMA_PC_W-1:0] addr;
  pma_word_t            word;
  modport core (output addr, input word);
  modport rom  (input addr, output word);
endinterface

// >>> hdl/pma_rom.sv
/*
  Program word store held in flip-flops; the number of words is set by the variant.
  Assumes the address arriving is already folded into the implemented range.
*/
`timescale 1ns/1ps
`include "pmaddr_map.svh"
module pma_rom #(
  parameter int WORDS = `PMA_WORDS_BIG
) (
  input  wire logic               clock,
  input  wire logic               wrEn,
  input  wire pma_pkg::pma_pc_t   wrAddr,
  input  wire pma_pkg::pma_word_t wrData,
  pma_rom_if.rom                  port
);
  import pma_pkg::*;
  localparam int AW = $clog2(WORDS);
  pma_word_t mem [WORDS];
  // ----------------------------------------
  // storage: loader writes, fetch reads
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr[AW-1:0]] <= wrData;
    end
  end
  // read is combinational; the top registers the word
  assign port.word = mem[port.addr[AW-1:0]];
endmodule

// >>> hdl/pma_core.sv
/*
  Program counter and program memory address former with a separate data port.
  Assumes the fetch logic asserts step once per instruction and intReq for one
  cycle when an interrupt is taken; loading the store happens before run.
  The store and the data bytes have no reset of their own: words never loaded
  read as unknown, so the loader must fill them before a fetch is relied on.
*/
// Behaviour
// R1: the program counter is 13 bits wide over a space of 8K words of 14 bits.
// R2: the big variant implements 8K words and the small one 4K words.
// R3: an address above the implemented memory wraps back into it without fault.
// R4: after any reset the program counter holds word address zero.
// R5: a taken interrupt sends the next fetch to word address four.
// R6: program and data memory have separate buses usable in the same cycle.
// R7: the small variant drops the top counter bit when forming the address.
`timescale 1ns/1ps
`include "pmaddr_map.svh"
module pma_core #(
  parameter bit SMALL = 1'b0
) (
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    step,
  input  wire logic                    jump,
  input  wire pma_pkg::pma_pc_t        jumpAddr,
  input  wire logic                    intReq,
  input  wire logic                    loadEn,
  input  wire pma_pkg::pma_pc_t        loadAddr,
  input  wire pma_pkg::pma_word_t      loadData,
  input  wire logic                    dataWr,
  input  wire logic [`PMA_DATA_AW-1:0] dataAddr,
  input  wire logic [`PMA_DATA_W-1:0]  dataIn,
  output pma_pkg::pma_pc_t             pc,
  output pma_pkg::pma_word_t           instr,
  output logic                         instrValid,
  output logic [`PMA_DATA_W-1:0]       dataOut
);
  import pma_pkg::*;

  localparam int WORDS = SMALL ? `PMA_WORDS_SMALL : `PMA_WORDS_BIG;

  pma_pc_t                pc_r;
  pma_pc_t                pc_nxt;
  pma_word_t              instr_r;
  logic                   valid_r;
  logic [`PMA_DATA_W-1:0] dout_r;
  logic [`PMA_DATA_W-1:0] dmem [2**`PMA_DATA_AW];

  pma_rom_if romBus ();

  // ----------------------------------------
  // address folding
  // ----------------------------------------
  // fold into the implemented range; a mask costs no logic, unlike a compare
  function automatic pma_pc_t foldAddr(input pma_pc_t a);
    pma_pc_t f;
    f = a;
    if (SMALL) begin
      f[`PMA_PC_W-1] = 1'b0; // see R7 see R3
    end
    return f;
  endfunction

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  // interrupt beats jump beats step
  always_comb begin
    pc_nxt = pc_r;
    if (intReq) begin
      pc_nxt = `PMA_INT_VEC; // see R5
    end else if (jump) begin
      pc_nxt = jumpAddr;
    end else if (step) begin
      pc_nxt = pc_r + 13'h0001; // see R1, rolls over at 8K
    end
  end

  // async reset parks the counter on the reset vector before any clock runs,
  // so the first fetch after release always comes from word zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= `PMA_RESET_VEC; // see R4
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // ----------------------------------------
  // program fetch bus
  // ----------------------------------------
  assign romBus.addr = foldAddr(pc_r);

  pma_rom #(
    .WORDS (WORDS) // see R2
  ) u_pma_rom (
    .clock  (clock),
    .wrEn   (loadEn),
    .wrAddr (foldAddr(loadAddr)), // see R7
    .wrData (loadData),
    .port   (romBus.rom)
  );

  // fetched word registered so outputs come from flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_r <= '0;
    end else begin
      instr_r <= romBus.word;
    end
  end

  // valid rises on the first edge out of reset and then stays up; it says a
  // fetch happened, not that the word at that address was ever loaded
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= 1'b0; // see R4
    end else begin
      valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // data bus, independent of the fetch path
  // ----------------------------------------
  // no reset on the bytes: clearing all of them would cost more than it buys
  always_ff @(posedge clock) begin
    if (dataWr) begin
      dmem[dataAddr] <= dataIn; // see R6
    end
  end

  // read port shows the old byte when a write hits the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dout_r <= '0;
    end else begin
      dout_r <= dmem[dataAddr]; // see R6
    end
  end

  assign pc         = pc_r;
  assign instr      = instr_r;
  assign instrValid = valid_r;
  assign dataOut    = dout_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a data write, then a quiet cycle on the same address
  sequence s_data_write;
    dataWr;
  endsequence

  sequence s_data_settle;
    !dataWr && $stable(dataAddr);
  endsequence

  // the vector is loaded one edge after the request
  a_int_vector_taken: assert property (@(posedge clock) disable iff (!arst_n) // see R5
    intReq |=> pc == 13'h0004) else $error("interrupt did not reach vector");

  // a plain step adds one over the full 13 bits
  a_step_adds_one: assert property (@(posedge clock) disable iff (!arst_n) // see R1
    step && !jump && !intReq |=> pc == $past(pc) + 13'h0001)
    else $error("step did not advance counter");

  // counter end point: the top word rolls over to zero on both variants
  a_pc_rollover: assert property (@(posedge clock) disable iff (!arst_n) // see R1
    step && !jump && !intReq && pc == 13'h1FFF |=> pc == 13'h0000)
    else $error("counter did not roll over at the top");

  // the small variant never presents the top counter bit to the store
  a_small_fold: assert property (@(posedge clock) disable iff (!arst_n) // see R7
    SMALL |-> romBus.addr[12] == 1'b0) else $error("small variant address not folded");

  // a jump above 4K on the small variant lands on its alias below
  a_jump_fold: assert property (@(posedge clock) disable iff (!arst_n) // see R7
    SMALL && jump && !intReq |=> romBus.addr == ($past(jumpAddr) & 13'h0FFF))
    else $error("small variant jump not folded");

  // low address bits always follow the counter
  a_wrap_alias: assert property (@(posedge clock) disable iff (!arst_n) // see R3
    romBus.addr[11:0] == pc[11:0]) else $error("fetch address lost low bits");

  // the fetch address never leaves the implemented store
  a_fetch_range: assert property (@(posedge clock) disable iff (!arst_n) // see R3
    int'(romBus.addr) < WORDS) else $error("fetch address outside the store");

  // the big variant passes the counter through untouched
  a_big_direct: assert property (@(posedge clock) disable iff (!arst_n) // see R2
    !SMALL |-> romBus.addr == pc) else $error("big variant address altered");

  // no request, no movement
  a_hold_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !step && !jump && !intReq |=> $stable(pc)) else $error("counter moved while idle");

  // a jump without an interrupt loads its target
  a_jump_load: assert property (@(posedge clock) disable iff (!arst_n)
    jump && !intReq |=> pc == $past(jumpAddr)) else $error("jump target not loaded");

  // words never loaded read as unknown, hence case equality here
  a_fetch_word: assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |=> instr === $past(romBus.word)) else $error("fetched word not captured");

  // valid follows the first edge after reset and never drops
  a_valid_up: assert property (@(posedge clock) disable iff (!arst_n) // see R4
    1'b1 |=> instrValid) else $error("fetch valid low outside reset");

  // counter sits on the reset vector for as long as reset is low
  a_reset_zero: assert property (@(posedge clock) // see R4
    !arst_n |-> pc == 13'h0000) else $error("counter not zero in reset");

  // registered outputs are cleared while reset is low
  a_reset_outputs: assert property (@(posedge clock) // see R4
    !arst_n |-> instr == '0 && !instrValid && dataOut == '0)
    else $error("outputs not cleared in reset");

  // a data access never stalls the fetch side
  a_data_no_stall: assert property (@(posedge clock) disable iff (!arst_n) // see R6
    dataWr && step && !jump && !intReq |=> pc == $past(pc) + 13'h0001)
    else $error("fetch stalled during data write");

  // a written byte reads back two edges later
  a_data_write: assert property (@(posedge clock) disable iff (!arst_n) // see R6
    s_data_write ##1 s_data_settle |=> dataOut == $past(dataIn, 2))
    else $error("data write not read back");
endmodule

// >>> bench/pma_fetch_model.sv
/*
  Fetch-side partner: steps the counter while run is high, takes interrupts.
  Assumes the bench calls take_int off the clock edge.
*/
`timescale 1ns/1ps
module pma_fetch_model (
  input  wire logic clock,
  input  wire logic run,
  output logic      step,
  output logic      intReq
);
  // step is a level, one instruction per edge while running
  assign step = run;
  initial intReq = 1'b0;
  // one-cycle request, as the core expects a single taken interrupt
  task automatic take_int();
    @(posedge clock);
    #1 intReq = 1'b1;
    @(posedge clock);
    #1 intReq = 1'b0;
  endtask
endmodule

// >>> bench/pma_core_tb_top.sv
/*
  Bench for the address former: both variants side by side on shared inputs.
  Assumes the fetch model drives step and intReq.
*/
`timescale 1ns/1ps
module pma_core_tb_top;
  import pma_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, run = 1'b0, jump = 1'b0, loadEn = 1'b0, dataWr = 1'b0;
  logic step, intReq, vB, vS;
  pma_pc_t jumpAddr = '0, loadAddr = '0, pcB, pcS;
  pma_word_t loadData = '0, wB, wS;
  logic [7:0] dataIn = '0, dB, dS;
  logic [8:0] dataAddr = '0;
  int fail_count = 0, checks = 0;
  initial forever #10 clock = ~clock;
  pma_fetch_model u_pma_fetch_model (.clock(clock), .run(run), .step(step), .intReq(intReq));
  pma_core #(.SMALL(1'b0)) u_pma_core (.clock(clock), .arst_n(arst_n), .step(step),
    .jump(jump), .jumpAddr(jumpAddr), .intReq(intReq), .loadEn(loadEn), .loadAddr(loadAddr),
    .loadData(loadData), .dataWr(dataWr), .dataAddr(dataAddr), .dataIn(dataIn), .pc(pcB),
    .instr(wB), .instrValid(vB), .dataOut(dB));
  // small variant shares every input, so a folded load lands in both
  pma_core #(.SMALL(1'b1)) u_pma_core_small (.clock(clock), .arst_n(arst_n), .step(step),
    .jump(jump), .jumpAddr(jumpAddr), .intReq(intReq), .loadEn(loadEn), .loadAddr(loadAddr),
    .loadData(loadData), .dataWr(dataWr), .dataAddr(dataAddr), .dataIn(dataIn), .pc(pcS),
    .instr(wS), .instrValid(vS), .dataOut(dS));
  // ----------------------------------------
  // compare and helper tasks
  // ----------------------------------------
  task automatic cpc(pma_pc_t g, pma_pc_t e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t pc %h exp %h", $time, g, e);
    end
  endtask
  task automatic cwd(pma_word_t g, pma_word_t e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic load(pma_pc_t a, pma_word_t d);
    loadEn = 1'b1; loadAddr = a; loadData = d;
    tick();
    loadEn = 1'b0;
    // idle edge so back-to-back loads never toggle the strobe in one step
    tick();
  endtask
  task automatic jmp(pma_pc_t a);
    jump = 1'b1; jumpAddr = a;
    tick();
    jump = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cpc(pcB, 13'h0000);
    cpc(pcS, 13'h0000);
    cwd({13'h0000, vB}, 14'h0000);
    cwd({13'h0000, vS}, 14'h0000);
    cwd({6'h00, dB}, 14'h0000);
    cwd({6'h00, dS}, 14'h0000);
    arst_n = 1'b1;
    tick();
    cwd({13'h0000, vB}, 14'h0001);
    cwd({13'h0000, vS}, 14'h0001);
    cpc(pcB, 13'h0000);
    cpc(pcS, 13'h0000);
  endtask
  task automatic t_wrap();
    load(13'h1005, 14'h15A5);
    load(13'h0005, 14'h2A5A);
    jmp(13'h1005);
    tick();
    cwd(wB, 14'h15A5);
    cwd(wS, 14'h2A5A);
  endtask
  task automatic t_int();
    load(13'h0004, 14'h3C3C);
    run = 1'b1;
    tick();
    run = 1'b0;
    u_pma_fetch_model.take_int();
    cpc(pcB, 13'h0004);
    cpc(pcS, 13'h0004);
    tick();
    cwd(wB, 14'h3C3C);
    cwd(wS, 14'h3C3C);
  endtask
  task automatic t_roll();
    jmp(13'h1FFF);
    run = 1'b1;
    tick();
    run = 1'b0;
    cpc(pcB, 13'h0000);
    cpc(pcS, 13'h0000);
  endtask
  // data write while fetch keeps stepping: both buses in one cycle
  task automatic t_data();
    // let an edge pass so run is not lowered and raised in one step
    tick();
    run = 1'b1; dataWr = 1'b1; dataAddr = 9'h1AB; dataIn = 8'h5A;
    tick();
    dataWr = 1'b0;
    tick();
    run = 1'b0;
    cwd({6'h00, dB}, 14'h005A);
    cwd({6'h00, dS}, 14'h005A);
    cpc(pcB, 13'h0002);
    cpc(pcS, 13'h0002);
  endtask
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog sized well past the under thirty cycles of the run
  initial begin
    #100000;
    fail_count++;
    results();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    t_reset();
    t_wrap();
    t_int();
    t_roll();
    t_data();
    results();
  end
endmodule
